// File: read_mode_pkg.sv
/*
 * read_mode_pkg: constants for the sensor read-mode configuration block.
 * assumes a 16-bit register port addressed by register index, one core clock.
 */
package read_mode_pkg;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// register map (register indices)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_READ_MODE_CTX_B = 8'h20; // context B read mode
	localparam logic [7:0] REG_READ_MODE_CTX_A = 8'h21; // context A read mode

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_BINNING     = 15;
	localparam int BIT_ZOOM_EN     = 13;
	localparam int BIT_ZOOM_HI     = 12;
	localparam int BIT_ZOOM_LO     = 11;
	localparam int BIT_ONE_ADC     = 10;
	localparam int BIT_SHOW_BORDER = 9;
	localparam int BIT_OVERSIZE    = 8;
	localparam int BIT_COL_SKIP_EN = 7;
	localparam int BIT_COL_SKIP_HI = 6;
	localparam int BIT_COL_SKIP_LO = 5;
	localparam int BIT_ROW_SKIP_EN = 4;
	localparam int BIT_ROW_SKIP_HI = 3;
	localparam int BIT_ROW_SKIP_LO = 2;
	localparam int BIT_MIRROR_COL  = 1;
	localparam int BIT_MIRROR_ROW  = 0;

	// ----------------------------------------------------------------
	// reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_CTX_B  = 16'h0000;
	localparam logic [15:0] RST_CTX_A  = 16'h8490; // binning, one adc, col/row skip en
	localparam logic [15:0] MASK_CTX_B = 16'hBFFF; // bit 14 reserved
	localparam logic [15:0] MASK_CTX_A = 16'h84FF; // A has no zoom/border fields

	// ----------------------------------------------------------------
	// geometry constants
	// ----------------------------------------------------------------
	localparam logic [3:0] BORDER_EXTRA = 4'h8; // rows and columns added by border
	localparam logic [3:0] BORDER_WIDTH = 4'h4; // border pixels on each side of the array

endpackage : read_mode_pkg

// File: skip_factor_decode.sv
/*
 * skip_factor_decode: turns an enable bit and a two-bit code into a factor.
 * assumes code 00..11 maps to 2, 4, 8, 16; disabled gives factor 1.
 */
module skip_factor_decode (
	// code in
	input  wire logic       i_enable,
	input  wire logic [1:0] i_code,
	// factor out, one-hot power of two
	output logic      [4:0] o_factor
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// shift of one by code plus one; factor 1 means normal readout
	assign o_factor = i_enable ? (5'h02 << i_code) : 5'h01;

endmodule : skip_factor_decode

// File: sensor_read_mode_control.sv
/*
 * sensor_read_mode_control: holds two read-mode contexts and produces the
 * effective readout settings plus line and frame geometry adjustments.
 * assumes register writes arrive synchronous to i_core_clk and a frame-start
 * pulse is supplied by the readout timing generator.
 */

module sensor_read_mode_control
	import read_mode_pkg::*;
#(
	parameter int ADDR_W = 11 // window start/size width
) (
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	// register port
	input  wire logic [7:0]        i_reg_addr,
	input  wire logic              i_reg_wr,
	input  wire logic [15:0]       i_reg_wdata,
	output logic      [15:0]       o_reg_rdata,
	// context select and frame timing
	input  wire logic              i_read_context_select,
	input  wire logic              i_frame_start,
	// window geometry
	input  wire logic [ADDR_W-1:0] i_col_start,
	input  wire logic [ADDR_W-1:0] i_col_size,
	input  wire logic [ADDR_W-1:0] i_row_start,
	input  wire logic [ADDR_W-1:0] i_row_size,
	// effective readout settings
	output logic                   o_binning,
	output logic                   o_one_adc,
	output logic                   o_pixclk_half,
	output logic      [4:0]        o_zoom_factor,
	output logic      [4:0]        o_zoom_blank_rows,
	output logic      [4:0]        o_col_skip,
	output logic      [4:0]        o_row_skip,
	output logic      [ADDR_W-1:0] o_col_first,
	output logic      [ADDR_W-1:0] o_col_last,
	output logic                   o_col_dir_down,
	output logic      [ADDR_W-1:0] o_row_first,
	output logic      [ADDR_W-1:0] o_row_last,
	output logic                   o_row_dir_down,
	// border geometry adjustments
	output logic                   o_border_on,
	output logic      [3:0]        o_border_width,
	output logic      [3:0]        o_extra_valid_rows,
	output logic      [3:0]        o_extra_valid_cols,
	output logic      [3:0]        o_extra_vblank_rows,
	output logic      [3:0]        o_extra_hblank_cols
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [15:0] ctx_a_q;      // software view of context A
	logic [15:0] ctx_b_q;      // software view of context B
	logic [15:0] act_a_q;      // frame-synced copy of context A
	logic [15:0] act_b_q;      // frame-synced copy of context B
	logic        sel_q;        // frame-synced context select

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire hit_a = i_reg_addr == REG_READ_MODE_CTX_A;
	wire hit_b = i_reg_addr == REG_READ_MODE_CTX_B;
	wire wr_a  = i_reg_wr && hit_a;
	wire wr_b  = i_reg_wr && hit_b;

	// unmapped indices read zero; reserved bits read zero via the masks
	assign o_reg_rdata = hit_a ? ctx_a_q :
	                     hit_b ? ctx_b_q : 16'h0000;

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	// written values are stored at once so software reads back immediately
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctx_a_q <= RST_CTX_A;
			ctx_b_q <= RST_CTX_B;
		end else begin
			if (wr_a) begin
				ctx_a_q <= i_reg_wdata & MASK_CTX_A;
			end
			if (wr_b) begin
				ctx_b_q <= i_reg_wdata & MASK_CTX_B;
			end
		end
	end

	// ----------------------------------------------------------------
	// frame-synchronised shadow copies
	// ----------------------------------------------------------------
	// shadows only move at frame start so no shadowed setting changes mid-frame;
	// a write in the frame-start cycle is taken into the shadow directly
	wire [15:0] next_a = wr_a ? (i_reg_wdata & MASK_CTX_A) : ctx_a_q;
	wire [15:0] next_b = wr_b ? (i_reg_wdata & MASK_CTX_B) : ctx_b_q;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			act_a_q <= RST_CTX_A;
			act_b_q <= RST_CTX_B;
			sel_q   <= 1'b0;
		end else if (i_frame_start) begin
			act_a_q <= next_a;
			act_b_q <= next_b;
			sel_q   <= i_read_context_select;
		end
	end

	// ----------------------------------------------------------------
	// context selection
	// ----------------------------------------------------------------
	wire [15:0] act = sel_q ? act_b_q : act_a_q;

	// zoom, border and mirrors are taken only from context B's word
	wire zoom_en    = act_b_q[BIT_ZOOM_EN];
	wire [1:0] zoom_code = act_b_q[BIT_ZOOM_HI:BIT_ZOOM_LO];
	wire oversize   = act_b_q[BIT_OVERSIZE];
	// show-border is not frame-synced: use the live software bit
	wire show_bdr   = ctx_b_q[BIT_SHOW_BORDER];
	wire mirror_col = act_b_q[BIT_MIRROR_COL];
	wire mirror_row = act_b_q[BIT_MIRROR_ROW];

	// skip fields: context A's enables and codes are stored, but its codes are
	// forced to zero here, so context A skips at the smallest factor when enabled
	wire       cskip_en   = act[BIT_COL_SKIP_EN];
	wire [1:0] cskip_code = sel_q ? act[BIT_COL_SKIP_HI:BIT_COL_SKIP_LO] : 2'h0;
	wire       rskip_en   = act[BIT_ROW_SKIP_EN];
	wire [1:0] rskip_code = sel_q ? act[BIT_ROW_SKIP_HI:BIT_ROW_SKIP_LO] : 2'h0;

	// ----------------------------------------------------------------
	// factor decoders
	// ----------------------------------------------------------------
	logic [4:0] zoom_f;   // zoom factor
	logic [4:0] cskip_f;  // column skip factor
	logic [4:0] rskip_f;  // row skip factor

	skip_factor_decode u_zoom_dec (
		.i_enable (zoom_en),
		.i_code   (zoom_code),
		.o_factor (zoom_f)
	);

	skip_factor_decode u_cskip_dec (
		.i_enable (cskip_en),
		.i_code   (cskip_code),
		.o_factor (cskip_f)
	);

	skip_factor_decode u_rskip_dec (
		.i_enable (rskip_en),
		.i_code   (rskip_code),
		.o_factor (rskip_f)
	);

	// ----------------------------------------------------------------
	// mirror address ranges
	// ----------------------------------------------------------------
	wire [ADDR_W-1:0] col_end  = i_col_start + i_col_size;
	wire [ADDR_W-1:0] row_end  = i_row_start + i_row_size;
	wire [ADDR_W-1:0] col_fst  = mirror_col ? col_end : i_col_start;
	wire [ADDR_W-1:0] col_lst  = mirror_col ? ADDR_W'(i_col_start + 1'b1)
	                                        : ADDR_W'(col_end - 1'b1);
	wire [ADDR_W-1:0] row_fst  = mirror_row ? row_end : i_row_start;
	wire [ADDR_W-1:0] row_lst  = mirror_row ? ADDR_W'(i_row_start + 1'b1)
	                                        : ADDR_W'(row_end - 1'b1);

	// ----------------------------------------------------------------
	// border geometry
	// ----------------------------------------------------------------
	// the border is added around the array whatever skip/zoom/mirror say
	wire [3:0] bdr_add  = oversize ? BORDER_EXTRA : 4'h0;
	wire [3:0] vld_add  = show_bdr ? bdr_add : 4'h0;
	wire [3:0] blk_add  = show_bdr ? 4'h0 : bdr_add;

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	// all outputs except o_reg_rdata come from flops, so they lag the sources by a cycle
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_binning           <= 1'b0;
			o_one_adc           <= 1'b0;
			o_pixclk_half       <= 1'b0;
			o_zoom_factor       <= 5'h01;
			o_zoom_blank_rows   <= 5'h00;
			o_col_skip          <= 5'h01;
			o_row_skip          <= 5'h01;
			o_col_first         <= '0;
			o_col_last          <= '0;
			o_col_dir_down      <= 1'b0;
			o_row_first         <= '0;
			o_row_last          <= '0;
			o_row_dir_down      <= 1'b0;
			o_border_on         <= 1'b0;
			o_border_width      <= 4'h0;
			o_extra_valid_rows  <= 4'h0;
			o_extra_valid_cols  <= 4'h0;
			o_extra_vblank_rows <= 4'h0;
			o_extra_hblank_cols <= 4'h0;
		end else begin
			// binning is a context A setting only
			o_binning           <= ~sel_q & act_a_q[BIT_BINNING];
			o_one_adc           <= act[BIT_ONE_ADC];
			o_pixclk_half       <= act[BIT_ONE_ADC];
			o_zoom_factor       <= zoom_f;
			o_zoom_blank_rows   <= 5'(zoom_f - 5'h01);
			o_col_skip          <= cskip_f;
			o_row_skip          <= rskip_f;
			o_col_first         <= col_fst;
			o_col_last          <= col_lst;
			o_col_dir_down      <= mirror_col;
			o_row_first         <= row_fst;
			o_row_last          <= row_lst;
			o_row_dir_down      <= mirror_row;
			o_border_on         <= oversize;
			o_border_width      <= oversize ? BORDER_WIDTH : 4'h0;
			o_extra_valid_rows  <= vld_add;
			o_extra_valid_cols  <= vld_add;
			o_extra_vblank_rows <= blk_add;
			o_extra_hblank_cols <= blk_add;
		end
	end

endmodule : sensor_read_mode_control

// File: sensor_read_mode_control_asserts.sv
/* sensor_read_mode_asserts: port-level checks for sensor_read_mode_control.
 * assumes one clock domain and reset i_rst asynchronous, active high. */
module sensor_read_mode_asserts #(
	parameter int ADDR_W = 11 // must match the design window width
) (
	// clock, reset and frame timing
	input wire logic              i_core_clk,
	input wire logic              i_rst,
	input wire logic              i_frame_start,
	// window geometry
	input wire logic [ADDR_W-1:0] i_col_start,
	input wire logic [ADDR_W-1:0] i_col_size,
	input wire logic [ADDR_W-1:0] i_row_start,
	input wire logic [ADDR_W-1:0] i_row_size,
	// effective settings watched
	input wire logic              o_one_adc,
	input wire logic              o_pixclk_half,
	input wire logic [4:0]        o_zoom_factor,
	input wire logic [4:0]        o_zoom_blank_rows,
	input wire logic [4:0]        o_col_skip,
	input wire logic [ADDR_W-1:0] o_col_last,
	input wire logic              o_col_dir_down,
	input wire logic [ADDR_W-1:0] o_row_last,
	input wire logic              o_row_dir_down,
	input wire logic              o_border_on,
	input wire logic [3:0]        o_border_width,
	input wire logic [3:0]        o_extra_valid_rows,
	input wire logic [3:0]        o_extra_vblank_rows
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// synced outputs may move only two edges after a frame start or a reset
	a_sync_hold: assert property (!$past(i_frame_start) && !$past(i_frame_start, 2)
		&& !$past(i_rst) && !$past(i_rst, 2) |-> $stable(o_col_skip) && $stable(o_zoom_factor)
		&& $stable(o_border_on) && $stable(o_col_dir_down) && $stable(o_one_adc))
		else $error("synced setting moved without frame start");
	a_zoom_code: assert property (o_zoom_factor inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
		else $error("zoom factor illegal");
	a_zoom_blank: assert property (o_zoom_blank_rows == o_zoom_factor - 5'h01)
		else $error("blank rows not zoom minus one");
	a_adc_pixclk: assert property (o_pixclk_half == o_one_adc)
		else $error("pixel clock not halved with one converter");
	a_border_width: assert property (o_border_width == (o_border_on ? 4'h4 : 4'h0))
		else $error("border width wrong");
	a_border_shown: assert property (o_extra_valid_rows != 4'h0 |-> o_border_on
		&& o_extra_valid_rows == 4'h8 && o_extra_vblank_rows == 4'h0)
		else $error("shown border extension wrong");
	a_border_hidden: assert property (o_extra_vblank_rows != 4'h0 |-> o_border_on
		&& o_extra_vblank_rows == 4'h8 && o_extra_valid_rows == 4'h0)
		else $error("hidden border blanking wrong");
	a_col_mirror: assert property (o_col_dir_down && $stable(i_col_start) && $stable(i_col_size)
		|-> o_col_last == i_col_start + 1'b1) else $error("mirrored column end wrong");
	a_row_mirror: assert property (o_row_dir_down && $stable(i_row_start) && $stable(i_row_size)
		|-> o_row_last == i_row_start + 1'b1) else $error("mirrored row end wrong");
	c_zoom_max: cover property (o_zoom_factor == 5'h10);
	c_mirror_both: cover property (o_col_dir_down && o_row_dir_down);
	c_border_shown: cover property (o_extra_valid_rows == 4'h8);
endmodule : sensor_read_mode_asserts

bind sensor_read_mode_control sensor_read_mode_asserts #(.ADDR_W(ADDR_W)) u_asserts (
	.i_core_clk, .i_rst, .i_frame_start, .i_col_start, .i_col_size, .i_row_start, .i_row_size,
	.o_one_adc, .o_pixclk_half, .o_zoom_factor, .o_zoom_blank_rows, .o_col_skip, .o_col_last,
	.o_col_dir_down, .o_row_last, .o_row_dir_down, .o_border_on, .o_border_width,
	.o_extra_valid_rows, .o_extra_vblank_rows);

// File: tb_sensor_read_mode_control.sv
/* tb_sensor_read_mode_control: self-checking bench with a register and shadow model.
 * assumes the design takes writes and frame starts on rising edges; we drive on falling. */
module tb_sensor_read_mode_control
	import read_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_core_clk, i_rst, i_reg_wr, i_read_context_select, i_frame_start;
	logic [7:0]  i_reg_addr;
	logic [15:0] i_reg_wdata, o_reg_rdata, ma, mb, sa, sb, lf; // ma/mb live, sa/sb shadows
	logic [10:0] i_col_start, i_col_size, i_row_start, i_row_size;
	logic [10:0] o_col_first, o_col_last, o_row_first, o_row_last;
	logic        o_binning, o_one_adc, o_pixclk_half, o_col_dir_down, o_row_dir_down, o_border_on;
	logic        ssel; // context sampled at the last frame start
	logic [4:0]  o_zoom_factor, o_zoom_blank_rows, o_col_skip, o_row_skip;
	logic [3:0]  o_border_width, o_extra_valid_rows, o_extra_valid_cols;
	logic [3:0]  o_extra_vblank_rows, o_extra_hblank_cols;
	int          n_mismatch, n_tests;
	sensor_read_mode_control u_dut (.i_core_clk, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
		.o_reg_rdata, .i_read_context_select, .i_frame_start, .i_col_start, .i_col_size,
		.i_row_start, .i_row_size, .o_binning, .o_one_adc, .o_pixclk_half, .o_zoom_factor,
		.o_zoom_blank_rows, .o_col_skip, .o_row_skip, .o_col_first, .o_col_last, .o_col_dir_down,
		.o_row_first, .o_row_last, .o_row_dir_down, .o_border_on, .o_border_width,
		.o_extra_valid_rows, .o_extra_valid_cols, .o_extra_vblank_rows, .o_extra_hblank_cols);
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic summarize;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h expected %h", $time, g, e);
		end
	endtask : cmp_out
	// readback is combinational on the address, so settle a moment first;
	// return on a falling edge so the next drive lands there too
	task automatic cmp_reg(input logic [7:0] a, input logic [15:0] e);
		i_reg_addr = a;
		#1;
		cmp_out(o_reg_rdata, e);
		@(negedge i_core_clk);
	endtask : cmp_reg
	// a write also lets one more edge pass so the live show-border bit can land
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		@(negedge i_core_clk);
		i_reg_wr = 1'b0;
		if (a == REG_READ_MODE_CTX_A) ma = d & 16'h84FF;
		if (a == REG_READ_MODE_CTX_B) mb = d & 16'hBFFF;
		@(negedge i_core_clk);
	endtask : wr
	// all expectations are worked from the model words, never from the design
	task automatic check;
		logic [15:0] act;
		logic [10:0] cf, cl, rf, rl;
		act = ssel ? sb : sa;
		cf = sb[1] ? i_col_start + i_col_size : i_col_start;
		cl = sb[1] ? i_col_start + 11'h001 : i_col_start + i_col_size - 11'h001;
		rf = sb[0] ? i_row_start + i_row_size : i_row_start;
		rl = sb[0] ? i_row_start + 11'h001 : i_row_start + i_row_size - 11'h001;
		cmp_out(16'({o_binning, o_one_adc, o_pixclk_half, o_col_dir_down, o_row_dir_down, o_border_on,
			o_border_width}), 16'({!ssel && sa[15], act[10], act[10], sb[1], sb[0], sb[8],
			sb[8] ? 4'h4 : 4'h0}));
		cmp_out(16'({o_zoom_factor, o_zoom_blank_rows}), sb[13] ? 16'({5'(2 << sb[12:11]),
			5'((2 << sb[12:11]) - 1)}) : 16'h0020);
		cmp_out(16'({o_col_skip, o_row_skip}), 16'({act[7] ? 5'(2 << act[6:5]) : 5'h01,
			act[4] ? 5'(2 << act[3:2]) : 5'h01}));
		cmp_out({o_extra_valid_rows, o_extra_valid_cols, o_extra_vblank_rows, o_extra_hblank_cols},
			sb[8] ? (mb[9] ? 16'h8800 : 16'h0088) : 16'h0000);
		cmp_out(16'(o_col_first), 16'(cf));
		cmp_out(16'(o_col_last), 16'(cl));
		cmp_out(16'(o_row_first), 16'(rf));
		cmp_out(16'(o_row_last), 16'(rl));
	endtask : check
	task automatic frame(input logic s);
		i_read_context_select = s;
		i_frame_start = 1'b1;
		@(negedge i_core_clk);
		i_frame_start = 1'b0;
		i_reg_wr = 1'b0;
		sa = ma;
		sb = mb;
		ssel = s;
		@(negedge i_core_clk);
		check;
	endtask : frame
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	// watchdog: the sequence needs well under 20000 cycles
	initial begin
		#200000;
		n_mismatch++;
		summarize;
	end
	initial begin
		{i_reg_wr, i_frame_start, i_read_context_select, i_reg_addr, i_reg_wdata} = '0;
		{i_col_start, i_col_size, i_row_start, i_row_size} = {11'h010, 11'h640, 11'h020, 11'h4B0};
		i_rst = 1'b1;
		{ma, mb, sa, sb, ssel, lf} = {16'h8490, 16'h0000, 16'h8490, 16'h0000, 1'b0, 16'h0012};
		repeat (5) @(negedge i_core_clk);
		i_rst = 1'b0;
		repeat (2) @(negedge i_core_clk);
		cmp_reg(REG_READ_MODE_CTX_A, 16'h8490);
		cmp_reg(REG_READ_MODE_CTX_B, 16'h0000);
		check;
		// unmapped and reserved bits, no frame start yet
		wr(8'h22, 16'hFFFF);
		cmp_reg(8'h22, 16'h0000);
		wr(REG_READ_MODE_CTX_A, 16'hFFFF);
		wr(REG_READ_MODE_CTX_B, 16'hFFFF);
		cmp_reg(REG_READ_MODE_CTX_A, 16'h84FF);
		cmp_reg(REG_READ_MODE_CTX_B, 16'hBFFF);
		check;
		// every zoom and skip code, mirror and border combination, both contexts
		for (int c = 0; c < 4; c++) begin
			wr(REG_READ_MODE_CTX_A, 16'(c[0] * 16'h8400 + c[1] * 16'h0093));
			wr(REG_READ_MODE_CTX_B, 16'h2090 | 16'(c * 16'h0925));
			frame(1'b1);
			wr(REG_READ_MODE_CTX_B, mb ^ 16'h0200);
			check;
			frame(1'b0);
		end
		// a write in the frame-start cycle reaches the new frame at once
		i_reg_addr = REG_READ_MODE_CTX_B;
		i_reg_wdata = 16'h2A52;
		i_reg_wr = 1'b1;
		mb = 16'h2A52 & 16'hBFFF;
		frame(1'b1);
		cmp_reg(REG_READ_MODE_CTX_B, 16'h2A52);
		// random words, geometry and context
		repeat (30) begin
			lf = lfsr(lf);
			i_col_start = lf[10:0];
			lf = lfsr(lf);
			i_col_size = lf[10:0];
			lf = lfsr(lf);
			wr(REG_READ_MODE_CTX_B, lf);
			lf = lfsr(lf);
			wr(REG_READ_MODE_CTX_A, lf & 16'hFF93);
			i_row_start = lf[14:4];
			i_row_size = lf[10:0];
			frame(lf[3]);
		end
		summarize;
	end
endmodule : tb_sensor_read_mode_control
